// ### rtl/nv_access_map.vh
// Register map, field positions, reset values and timing counts for the data EEPROM access control
// Operation
// - Write-start without write-enable already set is ignored; no write begins.
// - Write cycle timed by an internal timer asynchronous to system clock.
// - Hardware clears write-start when the write cycle ends.
// - Power-on clears write-enable so no write can start.
// - Power-on resets bank pointer to zero, hiding the bank 1 control register.
// - Write end sets the done flag regardless of interrupt enable.
// - Vector taken only with flag, both enables set and stack not full.
// - Done flag cleared automatically when the interrupt is serviced.
// - Control register at 040H bank 1; bits read, read-en, write, write-en.
// - Read starts only with read-enable; read-start clears at end; data holds.
`ifndef NV_ACCESS_MAP_VH
`define NV_ACCESS_MAP_VH

// ==========================================
// Addresses
`define NV_CTRL_OFS 8'h40
`define NV_LOC_OFS 8'h41
`define NV_BYTE_OFS 8'h42
`define NV_BANK_CTRL 8'h01
`define NV_CTRL_RESET 8'h00

// ==========================================
// Control fields
`define NV_RD_BIT 0
`define NV_READ_ENABLE_BIT_BIT 1
`define NV_WR_BIT 2
`define NV_WRITE_ENABLE_BIT_BIT 3

// ==========================================
// Timing
`define NV_READ_CYCLES 4'h3
`define NV_TIMER_DIV 8'h20
`define NV_WRITE_TICKS 8'h40

`endif

// ### rtl/nv_cell_array.v
// Small byte memory standing in for the data EEPROM array
`timescale 1ns/100ps
`default_nettype none
module nv_cell_array (
    input wire clk, // System clock
    input wire we, // Write strobe
    input wire [5:0] addr, // Cell index
    input wire [7:0] wdata, // Byte to store
    output reg [7:0] rdata // Registered read byte
);
    reg [7:0] mem [0:63];

    always @(posedge clk)
    begin
        if (we)
        begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end
endmodule // nv_cell_array
`default_nettype wire

// ### rtl/nv_access_ctrl.v
// Data EEPROM access control: control register, bank gating, timed cycles, done interrupt
`timescale 1ns/100ps
`default_nettype none
`include "nv_access_map.vh"
module nv_access_ctrl (
    input wire clk, // System clock, 100 MHz
    input wire rst, // Synchronous power-on reset, active high
    input wire timer_clk_tick, // Pulse from the free internal timer oscillator
    input wire [7:0] cpu_addr, // Data memory address within the bank
    input wire [7:0] cpu_wdata, // Data memory write byte
    input wire cpu_we, // Data memory write strobe
    input wire bank_we, // Write strobe for the bank pointer
    input wire [7:0] bank_wdata, // New bank pointer value
    input wire global_irq_enable, // Global interrupt enable from the core
    input wire nv_irq_enable, // EEPROM interrupt enable bit
    input wire stack_full, // Core stack has no free level
    input wire irq_ack, // Core is servicing the EEPROM vector
    output reg [7:0] cpu_rdata, // Read data for the addressed location
    output reg [7:0] bank_pointer, // Current data memory bank
    output reg nv_done_flag, // Write-complete request flag
    output reg irq_take, // Request to branch to the EEPROM vector
    output reg busy // A read or write cycle is running
);
    localparam ST_IDLE = 2'b00;
    localparam ST_WRITE = 2'b01;
    localparam ST_READ = 2'b10;
    localparam ST_LOAD = 2'b11;

    reg [7:0] nv_location_reg;
    reg [7:0] nv_byte_reg;
    reg rd_q, read_enable_bit_q, wr_q, write_enable_bit_q;
    reg [1:0] state_q;
    reg [7:0] tick_cnt_q;
    reg [3:0] rd_cnt_q;
    reg tick_s1_q, tick_s2_q, tick_s3_q;
    wire [7:0] cell_rdata;
    wire ctrl_sel;
    wire tick_evt;
    wire cell_we;
    wire write_end;
    wire read_end;

    // ==========================================
    // Timer crossing; the timer runs free of clk, so its edge is resynchronised
    always @(posedge clk)
    begin
        if (rst)
        begin
            tick_s1_q <= 1'b0;
            tick_s2_q <= 1'b0;
            tick_s3_q <= 1'b0;
        end
        else
        begin
            tick_s1_q <= timer_clk_tick;
            tick_s2_q <= tick_s1_q;
            tick_s3_q <= tick_s2_q;
        end
    end
    assign tick_evt = tick_s2_q & ~tick_s3_q;

    assign ctrl_sel = (bank_pointer == `NV_BANK_CTRL) && (cpu_addr == `NV_CTRL_OFS);
    assign write_end = (state_q == ST_WRITE) && tick_evt && (tick_cnt_q == `NV_WRITE_TICKS - 8'h01);
    assign read_end = (state_q == ST_READ) && (rd_cnt_q == `NV_READ_CYCLES);
    assign cell_we = write_end;

    nv_cell_array u_cells (
        .clk(clk),
        .we(cell_we),
        .addr(nv_location_reg[5:0]),
        .wdata(nv_byte_reg),
        .rdata(cell_rdata)
    );

    // ==========================================
    // Bank pointer
    always @(posedge clk)
    begin
        if (rst)
        begin
            bank_pointer <= 8'h00;
        end
        else if (bank_we)
        begin
            bank_pointer <= bank_wdata;
        end
    end

    // ==========================================
    // Location and data registers; both ignore CPU writes while a cycle runs
    always @(posedge clk)
    begin
        if (rst)
        begin
            nv_location_reg <= 8'h00;
            nv_byte_reg <= 8'h00;
        end
        else
        begin
            if (cpu_we && !busy && cpu_addr == `NV_LOC_OFS)
            begin
                nv_location_reg <= cpu_wdata;
            end
            if (state_q == ST_LOAD)
            begin
                nv_byte_reg <= cell_rdata;
            end
            else if (cpu_we && !busy && cpu_addr == `NV_BYTE_OFS)
            begin
                nv_byte_reg <= cpu_wdata;
            end
        end
    end

    // ==========================================
    // Control register and cycle sequencer
    always @(posedge clk)
    begin
        if (rst)
        begin
            rd_q <= 1'b0;
            read_enable_bit_q <= 1'b0;
            wr_q <= 1'b0;
            write_enable_bit_q <= 1'b0;
            state_q <= ST_IDLE;
            tick_cnt_q <= 8'h00;
            rd_cnt_q <= 4'h0;
            busy <= 1'b0;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                begin
                    if (cpu_we && ctrl_sel)
                    begin
                        read_enable_bit_q <= cpu_wdata[`NV_READ_ENABLE_BIT_BIT];
                        write_enable_bit_q <= cpu_wdata[`NV_WRITE_ENABLE_BIT_BIT];
                        // Start bits honour only enables already stored
                        if (cpu_wdata[`NV_WR_BIT] && write_enable_bit_q)
                        begin
                            wr_q <= 1'b1;
                            state_q <= ST_WRITE;
                            tick_cnt_q <= 8'h00;
                            busy <= 1'b1;
                        end
                        else if (cpu_wdata[`NV_RD_BIT] && read_enable_bit_q)
                        begin
                            rd_q <= 1'b1;
                            state_q <= ST_READ;
                            rd_cnt_q <= 4'h0;
                            busy <= 1'b1;
                        end
                    end
                end
                ST_WRITE:
                begin
                    if (cpu_we && ctrl_sel)
                    begin
                        read_enable_bit_q <= cpu_wdata[`NV_READ_ENABLE_BIT_BIT];
                        write_enable_bit_q <= cpu_wdata[`NV_WRITE_ENABLE_BIT_BIT];
                    end
                    if (tick_evt)
                    begin
                        tick_cnt_q <= tick_cnt_q + 8'h01;
                    end
                    if (write_end)
                    begin
                        wr_q <= 1'b0;
                        state_q <= ST_IDLE;
                        busy <= 1'b0;
                    end
                end
                ST_READ:
                begin
                    rd_cnt_q <= rd_cnt_q + 4'h1;
                    if (read_end)
                    begin
                        state_q <= ST_LOAD;
                    end
                end
                ST_LOAD:
                begin
                    rd_q <= 1'b0;
                    state_q <= ST_IDLE;
                    busy <= 1'b0;
                end
                default:
                begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ==========================================
    // Done flag and vector request; a write end beats a same-cycle service clear
    always @(posedge clk)
    begin
        if (rst)
        begin
            nv_done_flag <= 1'b0;
            irq_take <= 1'b0;
        end
        else
        begin
            if (write_end)
            begin
                nv_done_flag <= 1'b1;
            end
            else if (irq_ack)
            begin
                nv_done_flag <= 1'b0;
            end
            irq_take <= nv_done_flag && nv_irq_enable && global_irq_enable
                && !stack_full && !irq_ack;
        end
    end

    // ==========================================
    // Read-back mux; bits 7..4 of control read as zero
    always @(posedge clk)
    begin
        if (rst)
        begin
            cpu_rdata <= 8'h00;
        end
        else if (ctrl_sel)
        begin
            cpu_rdata <= {4'h0, write_enable_bit_q, wr_q, read_enable_bit_q, rd_q};
        end
        else if (cpu_addr == `NV_LOC_OFS)
        begin
            cpu_rdata <= nv_location_reg;
        end
        else if (cpu_addr == `NV_BYTE_OFS)
        begin
            cpu_rdata <= nv_byte_reg;
        end
        else
        begin
            cpu_rdata <= 8'h00;
        end
    end
endmodule // nv_access_ctrl
`default_nettype wire

// ### sim/nv_access_props.sv
// Concurrent checks on the EEPROM access control ports
`timescale 1ns/100ps
`default_nettype none
module nv_access_props (
    input wire logic clk, // Clock
    input wire logic rst, // Reset
    input wire logic bank_we, // Bank strobe
    input wire logic [7:0] bank_wdata, // Bank value
    input wire logic global_irq_enable, // Global enable
    input wire logic nv_irq_enable, // Local enable
    input wire logic stack_full, // Stack full
    input wire logic irq_ack, // Service
    input wire logic [7:0] bank_pointer, // Bank
    input wire logic nv_done_flag, // Done flag
    input wire logic irq_take, // Vector request
    input wire logic busy // Cycle running
);
    // ==========================================
    // Properties
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire req_ok = nv_done_flag && global_irq_enable && nv_irq_enable && !stack_full;
    a_reset_state: assert property (
        $fell(rst) |-> bank_pointer == 8'h00 && !nv_done_flag && !busy && !irq_take)
        else $error("state not cleared by reset");
    a_bank_load: assert property (
        bank_we |=> bank_pointer == $past(bank_wdata))
        else $error("bank pointer not loaded");
    a_busy_hold: assert property (
        $rose(busy) |-> busy[*3])
        else $error("cycle ended too soon");
    a_flag_rise: assert property (
        $rose(nv_done_flag) |-> $fell(busy))
        else $error("done flag without cycle end");
    a_flag_sticky: assert property (
        nv_done_flag && !irq_ack |=> nv_done_flag)
        else $error("done flag lost");
    a_ack_clears: assert property (
        irq_ack && !busy |=> !nv_done_flag)
        else $error("done flag kept after service");
    a_take_cause: assert property (
        irq_take |-> $past(req_ok))
        else $error("vector request without cause");
    a_take_when: assert property (
        req_ok && !irq_ack |=> irq_take)
        else $error("vector request missing");
    c_cycle: cover property ($rose(busy));
    c_done: cover property ($rose(nv_done_flag));
    c_take: cover property ($rose(irq_take));
endmodule // nv_access_props

bind nv_access_ctrl nv_access_props chk (.clk(clk), .rst(rst), .bank_we(bank_we),
    .bank_wdata(bank_wdata), .global_irq_enable(global_irq_enable),
    .nv_irq_enable(nv_irq_enable), .stack_full(stack_full), .irq_ack(irq_ack),
    .bank_pointer(bank_pointer), .nv_done_flag(nv_done_flag), .irq_take(irq_take),
    .busy(busy));
`default_nettype wire

// ### sim/data_eeprom_access_control_tb_top.sv
// Self-checking bench for the EEPROM access control
`timescale 1ns/100ps
`default_nettype none
module data_eeprom_access_control_tb_top;
    // ==========================================
    // Stimulus and result queue
    logic clk = 1'b0, rst = 1'b1, tick = 1'b0, we = 1'b0, bwe = 1'b0, gie = 1'b0;
    logic nie = 1'b0, sf = 1'b0, ack = 1'b0, probe = 1'b0, flag, take, busy;
    logic [7:0] addr = 8'h00, wd = 8'h00, bwd = 8'h00, rdata, bank, a, d;
    logic [10:0] q[$];
    int err_count = 0, n_compared = 0;
    always #5 clk = ~clk;
    // Unrelated period so the timer phase drifts; toggles never on a rising edge
    always #36 tick = ~tick;
    nv_access_ctrl dut (.clk(clk), .rst(rst), .timer_clk_tick(tick), .cpu_addr(addr),
        .cpu_wdata(wd), .cpu_we(we), .bank_we(bwe), .bank_wdata(bwd),
        .global_irq_enable(gie), .nv_irq_enable(nie), .stack_full(sf), .irq_ack(ack),
        .cpu_rdata(rdata), .bank_pointer(bank), .nv_done_flag(flag), .irq_take(take),
        .busy(busy));
    task automatic chk(input logic [10:0] exp, input logic [10:0] got);
        n_compared++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask
    task automatic stop_test;
        $display("compared=%0d errors=%0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic idle(input int n);
        repeat (n)
        begin
            @(posedge clk);
            we <= 1'b0;
            bwe <= 1'b0;
            ack <= 1'b0;
        end
    endtask
    // Leaves the strobe high so two calls land in consecutive cycles
    task automatic wr(input logic [7:0] ad, input logic [7:0] v);
        @(posedge clk);
        we <= 1'b1;
        addr <= ad;
        wd <= v;
    endtask
    task automatic setbank(input logic [7:0] b);
        @(posedge clk);
        we <= 1'b0;
        bwe <= 1'b1;
        bwd <= b;
        idle(1);
    endtask
    task automatic rd(input logic [7:0] ad, input logic [10:0] exp);
        idle(1);
        addr <= ad;
        q.push_back(exp);
        @(posedge clk);
        probe <= 1'b1;
        @(posedge clk);
        probe <= 1'b0;
    endtask
    task automatic wait_idle;
        int i;
        i = 0;
        while (busy !== 1'b0 && i < 3000)
        begin
            @(posedge clk);
            i++;
        end
        if (i == 3000)
        begin
            err_count++;
            stop_test();
        end
    endtask
    always @(posedge clk)
        if (probe)
            chk(q.pop_front(), {busy, flag, take, rdata});
    // ==========================================
    // Sequence
    initial
    begin
        a = 8'($urandom(32'h947C));
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk(11'h000, {3'b000, bank});
        setbank(8'h01);
        rd(8'h40, 11'h000);
        wr(8'h40, 8'h04);
        rd(8'h40, 11'h000);
        wr(8'h40, 8'h0C);
        rd(8'h40, 11'h008);
        for (int k = 0; k < 2; k++)
        begin
            a = 8'($urandom_range(63));
            d = 8'($urandom);
            wr(8'h41, a);
            wr(8'h42, d);
            wr(8'h40, 8'h08);
            wr(8'h40, 8'h0C);
            rd(8'h40, {3'b100, 8'h0C});
            wait_idle();
            rd(8'h40, {3'b010, 8'h08});
            gie <= 1'b1;
            nie <= 1'b1;
            sf <= 1'b1;
            rd(8'h40, {3'b010, 8'h08});
            sf <= 1'b0;
            rd(8'h40, {3'b011, 8'h08});
            @(posedge clk);
            ack <= 1'b1;
            rd(8'h40, {3'b000, 8'h08});
            gie <= 1'b0;
            nie <= 1'b0;
            wr(8'h41, a);
            wr(8'h42, ~d);
            wr(8'h40, 8'h02);
            wr(8'h40, 8'h03);
            idle(8);
            rd(8'h40, 11'h002);
            rd(8'h42, {3'b000, d});
        end
        wr(8'h40, 8'h00);
        wr(8'h40, 8'h01);
        rd(8'h40, 11'h000);
        setbank(8'h00);
        wr(8'h40, 8'h08);
        setbank(8'h01);
        rd(8'h40, 11'h000);
        // Second reset in mid-write, with write-enable and bank 1 set
        wr(8'h40, 8'h08);
        wr(8'h40, 8'h0C);
        idle(2);
        rst <= 1'b1;
        idle(4);
        rst <= 1'b0;
        chk(11'h000, {3'b000, bank});
        setbank(8'h01);
        rd(8'h40, 11'h000);
        stop_test();
    end
endmodule // data_eeprom_access_control_tb_top
`default_nettype wire
